// file: dca_pkg.sv
// Purpose: Shared constants and types for the DMA cycle arbiter
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte addresses
// Notes: Queue addresses are plain defaults, adjust to the memory map
package dca_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CTL_W = 8;
	localparam int PTR_W = 16;
	localparam int PWR_W = 2;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTL1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SRC0 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SRC1 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_DST0 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DST1 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PWR = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h1C;

	// Channel control register fields
	localparam int CTL_GO = 0;
	localparam int CTL_DONE = 1;
	localparam int CTL_TRIG = 2;
	localparam int CTL_DEMAND = 3;
	localparam int CTL_SRC_INC = 4;
	localparam int CTL_SRC_SPACE = 5;
	localparam int CTL_DST_INC = 6;
	localparam int CTL_DST_SPACE = 7;

	// Power control register fields
	localparam int PWR_GRANT = 0;
	localparam int PWR_ASK = 1;

	// Status register fields
	localparam int STAT_ACK = 0;
	localparam int STAT_CODE = 1;
	localparam int STAT_INSTR = 3;
	localparam int STAT_LAST = 4;

	// Special-function addresses of the serial buffers
	localparam logic [PTR_W-1:0] SERIAL_BUF_ADDR = 16'h0099;
	localparam logic [PTR_W-1:0] RX_QUEUE_ADDR = 16'h00F4;
	localparam logic [PTR_W-1:0] TX_QUEUE_ADDR = 16'h0085;

	localparam logic [CTL_W-1:0] CTL_RST = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [PWR_W-1:0] PWR_RST = 2'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {DCA_CH0, DCA_CH1, DCA_INSTR} dca_code_t;
	typedef enum logic [1:0] {DCA_LAST_NONE, DCA_LAST_CH0, DCA_LAST_CH1} dca_last_t;
endpackage : dca_pkg

// file: dca_arbiter.sv
// Purpose: Picks the next internal bus task: channel 0, channel 1 or instruction
// Assumes: i_cycle_done pulses once as each instruction or DMA byte completes
// Notes: Hold acknowledge pin is synchronised; all other flags are same-clock
//
// Summary of operation
// - One DMA channel per cycle, suspends instructions
// - Arbitrate after every DMA or instruction cycle
// - DMA register write forces another instruction
// - Channel 0 first, then channel 1, else instruction
// - Burst mode always requests
// - External demand requests on its demand flag
// - Serial demand: buffer with receive/transmit flag
// - Serial buffer matches only in special-function space
// - Receive queue nonempty requests, back to back
// - Transmit queue needs preceding instruction cycle
// - Lone alternate channel requests after instruction
// - Paired alternate channels take turns
// - Burst channel 1 may stall transmit-queue channel
// - Hold modes qualify requests using external space
// - Demand and trigger bits pick the mode
// - Go bit clear means never granted
// - Space and increment bits pick address space
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module dca_arbiter
	import dca_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [DATA_W-1:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [DATA_W-1:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic i_cycle_done,
	input wire logic i_instr_wrote_dma,
	input wire logic i_ext_demand_flag_ch0,
	input wire logic i_ext_demand_flag_ch1,
	input wire logic i_receive_flag,
	input wire logic i_transmit_flag,
	input wire logic i_rx_queue_nonempty,
	input wire logic i_tx_queue_space_flag,
	input wire logic i_hold_ack_n,
	output logic [1:0] o_grant_code,
	output logic o_grant_strobe,
	output logic o_suspend_instr
);
	typedef struct packed {
		logic aw_full;
		logic [ADDR_W-1:0] awaddr;
		logic w_full;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic [1:0][CTL_W-1:0] ctl;
		logic [1:0][PTR_W-1:0] src;
		logic [1:0][PTR_W-1:0] dst;
		logic [PWR_W-1:0] pwr;
		logic ack_s1;
		logic ack_s2;
		dca_code_t cur;
		logic instr_now;
		dca_last_t last;
		logic strobe;
		logic suspend;
	} dca_state_t;

	dca_state_t state_r;
	dca_state_t state_nxt;
	logic [1:0] req;
	logic [1:0] tq_hit;
	logic [1:0] hold_ok;
	logic [1:0] ext_flag;
	logic [DATA_W-1:0] bmask;
	logic wr_fire;

	default clocking dca_cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	assign ext_flag = {i_ext_demand_flag_ch1, i_ext_demand_flag_ch0};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			logic [CTL_W-1:0] cn;
			logic [CTL_W-1:0] cm;
			logic src_sfr;
			logic dst_sfr;
			logic src_ext;
			logic dst_ext;
			logic burst;
			logic ext_dem;
			logic sp_dem;
			logic alt_self;
			logic alt_other;
			logic mode;
			logic own_last;
			assign cn = state_r.ctl[gi];
			assign cm = state_r.ctl[1-gi];
			assign src_sfr = cn[CTL_SRC_SPACE] & ~cn[CTL_SRC_INC];
			assign dst_sfr = cn[CTL_DST_SPACE] & ~cn[CTL_DST_INC];
			assign src_ext = ~cn[CTL_SRC_SPACE];
			assign dst_ext = ~cn[CTL_DST_SPACE];
			assign burst = ~cn[CTL_DEMAND] & cn[CTL_TRIG];
			assign ext_dem = cn[CTL_DEMAND] & cn[CTL_TRIG];
			assign sp_dem = cn[CTL_DEMAND] & ~cn[CTL_TRIG];
			assign alt_self = ~cn[CTL_DEMAND] & ~cn[CTL_TRIG];
			assign alt_other = ~cm[CTL_DEMAND] & ~cm[CTL_TRIG] & cm[CTL_GO];
			assign own_last = (state_r.last == ((gi == 0) ? DCA_LAST_CH0 : DCA_LAST_CH1));
			assign tq_hit[gi] = sp_dem & dst_sfr & (state_r.dst[gi] == TX_QUEUE_ADDR)
				& i_tx_queue_space_flag & state_r.instr_now;
			always_comb begin
				mode = 1'b0;
				if (burst) begin
					mode = 1'b1;
				end else if (ext_dem) begin
					mode = ext_flag[gi];
				end else if (sp_dem) begin
					mode = (src_sfr & (state_r.src[gi] == SERIAL_BUF_ADDR) & i_receive_flag)
						| (dst_sfr & (state_r.dst[gi] == SERIAL_BUF_ADDR) & i_transmit_flag)
						| (src_sfr & (state_r.src[gi] == RX_QUEUE_ADDR) & i_rx_queue_nonempty)
						| tq_hit[gi];
				end else if (alt_self & ~alt_other) begin
					mode = state_r.instr_now;
				end else begin
					mode = state_r.instr_now & ~own_last;
				end
			end
			assign hold_ok[gi] = ~(src_ext | dst_ext)
				| (state_r.pwr[PWR_GRANT] & state_r.ack_s2)
				| (state_r.pwr[PWR_ASK] & ~state_r.ack_s2);
			assign req[gi] = mode & (~(|state_r.pwr) | hold_ok[gi]);
		end
	endgenerate

	assign bmask = {{8{state_r.wstrb[3]}}, {8{state_r.wstrb[2]}}, {8{state_r.wstrb[1]}}, {8{state_r.wstrb[0]}}};
	assign wr_fire = state_r.aw_full & state_r.w_full & ~state_r.bvalid;

	always_comb begin
		state_nxt = state_r;
		state_nxt.strobe = 1'b0;
		// Only the second stage is read by logic
		state_nxt.ack_s1 = i_hold_ack_n;
		state_nxt.ack_s2 = state_r.ack_s1;

		if (i_s_axi_awvalid & state_r.awrdy) begin
			state_nxt.aw_full = 1'b1;
			state_nxt.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid & state_r.wrdy) begin
			state_nxt.w_full = 1'b1;
			state_nxt.wdata = i_s_axi_wdata;
			state_nxt.wstrb = i_s_axi_wstrb;
		end
		if (state_r.bvalid & i_s_axi_bready) begin
			state_nxt.bvalid = 1'b0;
		end
		// Register write once both halves are held
		if (wr_fire) begin
			state_nxt.aw_full = 1'b0;
			state_nxt.w_full = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = RESP_OKAY;
			unique case (state_r.awaddr)
				OFS_CTL0: state_nxt.ctl[0] = CTL_W'((state_r.ctl[0] & ~bmask) | (state_r.wdata & bmask));
				OFS_CTL1: state_nxt.ctl[1] = CTL_W'((state_r.ctl[1] & ~bmask) | (state_r.wdata & bmask));
				OFS_SRC0: state_nxt.src[0] = PTR_W'((state_r.src[0] & ~bmask) | (state_r.wdata & bmask));
				OFS_SRC1: state_nxt.src[1] = PTR_W'((state_r.src[1] & ~bmask) | (state_r.wdata & bmask));
				OFS_DST0: state_nxt.dst[0] = PTR_W'((state_r.dst[0] & ~bmask) | (state_r.wdata & bmask));
				OFS_DST1: state_nxt.dst[1] = PTR_W'((state_r.dst[1] & ~bmask) | (state_r.wdata & bmask));
				OFS_PWR: state_nxt.pwr = PWR_W'((state_r.pwr & ~bmask) | (state_r.wdata & bmask));
				OFS_STAT: state_nxt.bresp = RESP_OKAY;
				default: state_nxt.bresp = RESP_SLVERR;
			endcase
		end

		if (state_r.rvalid & i_s_axi_rready) begin
			state_nxt.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid & state_r.arrdy) begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp = RESP_OKAY;
			state_nxt.rdata = '0;
			unique case (i_s_axi_araddr)
				OFS_CTL0: state_nxt.rdata[CTL_W-1:0] = state_r.ctl[0];
				OFS_CTL1: state_nxt.rdata[CTL_W-1:0] = state_r.ctl[1];
				OFS_SRC0: state_nxt.rdata[PTR_W-1:0] = state_r.src[0];
				OFS_SRC1: state_nxt.rdata[PTR_W-1:0] = state_r.src[1];
				OFS_DST0: state_nxt.rdata[PTR_W-1:0] = state_r.dst[0];
				OFS_DST1: state_nxt.rdata[PTR_W-1:0] = state_r.dst[1];
				OFS_PWR: state_nxt.rdata[PWR_W-1:0] = state_r.pwr;
				OFS_STAT: begin
					state_nxt.rdata[STAT_ACK] = state_r.ack_s2;
					state_nxt.rdata[STAT_CODE +: 2] = state_r.cur;
					state_nxt.rdata[STAT_INSTR] = state_r.instr_now;
					state_nxt.rdata[STAT_LAST +: 2] = state_r.last;
				end
				default: state_nxt.rresp = RESP_SLVERR;
			endcase
		end

		if (i_cycle_done) begin
			state_nxt.strobe = 1'b1;
			if (state_r.instr_now & i_instr_wrote_dma) begin
				state_nxt.cur = DCA_INSTR;
			end else if (state_r.ctl[0][CTL_GO] & req[0]) begin
				state_nxt.cur = DCA_CH0;
			// requesting channel 1 wins only when channel 0 is not requesting
			end else if (state_r.ctl[1][CTL_GO] & req[1]) begin
				state_nxt.cur = DCA_CH1;
			end else begin
				state_nxt.cur = DCA_INSTR;
			end
			state_nxt.instr_now = (state_nxt.cur == DCA_INSTR);
			if (state_nxt.cur == DCA_CH0) begin
				state_nxt.last = DCA_LAST_CH0;
			end else if (state_nxt.cur == DCA_CH1) begin
				state_nxt.last = DCA_LAST_CH1;
			end
		end
		// instructions stop while a channel owns the bus
		state_nxt.suspend = (state_nxt.cur != DCA_INSTR);

		// Ready only when the holding slot is free, avoids overwrite
		state_nxt.awrdy = ~state_nxt.aw_full & ~state_nxt.bvalid;
		state_nxt.wrdy = ~state_nxt.w_full & ~state_nxt.bvalid;
		state_nxt.arrdy = ~state_nxt.rvalid;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= '0;
			state_r.ctl <= {CTL_RST, CTL_RST};
			state_r.src <= {PTR_RST, PTR_RST};
			state_r.dst <= {PTR_RST, PTR_RST};
			state_r.pwr <= PWR_RST;
			state_r.ack_s1 <= 1'b1;
			state_r.ack_s2 <= 1'b1;
			state_r.cur <= DCA_INSTR;
			state_r.instr_now <= 1'b1;
			state_r.last <= DCA_LAST_NONE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_s_axi_awready = state_r.awrdy;
	assign o_s_axi_wready = state_r.wrdy;
	assign o_s_axi_bresp = state_r.bresp;
	assign o_s_axi_bvalid = state_r.bvalid;
	assign o_s_axi_arready = state_r.arrdy;
	assign o_s_axi_rdata = state_r.rdata;
	assign o_s_axi_rresp = state_r.rresp;
	assign o_s_axi_rvalid = state_r.rvalid;
	assign o_grant_code = state_r.cur;
	assign o_grant_strobe = state_r.strobe;
	assign o_suspend_instr = state_r.suspend;

	suspend_match_a: assert property (o_suspend_instr == (o_grant_code != DCA_INSTR))
		else $error("suspend does not follow grant");
	rearb_pulse_a: assert property (i_cycle_done |=> o_grant_strobe ##1 (!o_grant_strobe || $past(i_cycle_done)))
		else $error("arbitration strobe missing");
	dma_write_block_a: assert property ((i_cycle_done && state_r.instr_now && i_instr_wrote_dma)
		|=> o_grant_code == DCA_INSTR)
		else $error("DMA register write did not block");
	ch0_priority_a: assert property ((i_cycle_done && !(state_r.instr_now && i_instr_wrote_dma)
		&& state_r.ctl[0][CTL_GO] && req[0]) |=> o_grant_code == DCA_CH0)
		else $error("channel 0 priority lost");
	go_clear_a: assert property ((i_cycle_done && !state_r.ctl[1][CTL_GO]) |=> o_grant_code != DCA_CH1)
		else $error("inactive channel granted");
	burst_req_a: assert property ((state_r.ctl[0][CTL_TRIG] && !state_r.ctl[0][CTL_DEMAND]
		&& state_r.pwr == PWR_RST) |-> req[0])
		else $error("burst channel not requesting");
	ext_demand0_a: assert property ((state_r.ctl[0][CTL_DEMAND] && state_r.ctl[0][CTL_TRIG]
		&& state_r.pwr == PWR_RST) |-> (req[0] == i_ext_demand_flag_ch0))
		else $error("channel 0 demand request wrong");
	ext_demand1_a: assert property ((state_r.ctl[1][CTL_DEMAND] && state_r.ctl[1][CTL_TRIG]
		&& state_r.pwr == PWR_RST) |-> (req[1] == i_ext_demand_flag_ch1))
		else $error("channel 1 demand request wrong");
	serial_rx_a: assert property ((state_r.ctl[0][CTL_DEMAND] && !state_r.ctl[0][CTL_TRIG]
		&& state_r.ctl[0][CTL_SRC_SPACE] && !state_r.ctl[0][CTL_SRC_INC]
		&& state_r.src[0] == SERIAL_BUF_ADDR && i_receive_flag && state_r.pwr == PWR_RST) |-> req[0])
		else $error("serial receive request missing");
	sfr_only_a: assert property ((state_r.ctl[0][CTL_DEMAND] && !state_r.ctl[0][CTL_TRIG]
		&& state_r.ctl[0][CTL_SRC_INC] && !state_r.ctl[0][CTL_DST_SPACE]) |-> !req[0])
		else $error("serial match outside function space");
	rxq_back_a: assert property ((state_r.ctl[0][CTL_DEMAND] && !state_r.ctl[0][CTL_TRIG]
		&& state_r.ctl[0][CTL_SRC_SPACE] && !state_r.ctl[0][CTL_SRC_INC]
		&& state_r.src[0] == RX_QUEUE_ADDR && i_rx_queue_nonempty && state_r.pwr == PWR_RST) |-> req[0])
		else $error("receive queue request missing");
	txq_space_a: assert property ((i_cycle_done && o_grant_code == DCA_CH0) |-> !tq_hit[0])
		else $error("back to back transmit queue cycle");
	alt_turn_a: assert property ((i_cycle_done && o_grant_code == DCA_CH1 && state_r.ctl[1][CTL_GO]
		&& !state_r.ctl[1][CTL_DEMAND] && !state_r.ctl[1][CTL_TRIG] && !state_r.ctl[0][CTL_GO])
		|=> o_grant_code != DCA_CH1)
		else $error("alternate channel ran twice");
	alt_pair_a: assert property ((i_cycle_done && state_r.last == DCA_LAST_CH0
		&& state_r.ctl[0][CTL_GO] && !state_r.ctl[0][CTL_DEMAND] && !state_r.ctl[0][CTL_TRIG]
		&& state_r.ctl[1][CTL_GO] && !state_r.ctl[1][CTL_DEMAND] && !state_r.ctl[1][CTL_TRIG])
		|=> o_grant_code != DCA_CH0)
		else $error("paired alternate channel repeated");
	history_track_a: assert property ((state_r.instr_now == (o_grant_code == DCA_INSTR))
		&& (o_grant_code == DCA_INSTR
		|| state_r.last == ((o_grant_code == DCA_CH0) ? DCA_LAST_CH0 : DCA_LAST_CH1)))
		else $error("cycle history out of step");
	hold_ask_a: assert property ((state_r.pwr[PWR_ASK] && !state_r.ack_s2
		&& state_r.ctl[0][CTL_TRIG] && !state_r.ctl[0][CTL_DEMAND]) |-> req[0])
		else $error("acknowledged request suppressed");
	hold_block_a: assert property (((|state_r.pwr) && !hold_ok[0]) |-> !req[0])
		else $error("hold check ignored");
	ack_sync_a: assert property ($rose(i_hold_ack_n) |-> ##2 state_r.ack_s2)
		else $error("acknowledge sync latency wrong");
endmodule : dca_arbiter

// file: dca_seq_model.sv
// Purpose: Sequencer model that ends each granted cycle
// Assumes: A step pulse starts the cycle now granted
// Notes: Shortest lengths used, longer ones behave alike
`timescale 1ns/1ps
module dca_seq_model #(
	parameter int LEN_I = 4,
	parameter int LEN_D = 2
)(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_step,
	input wire logic [1:0] i_code,
	output logic o_cycle_done
);
	int cnt;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt <= 0;
			o_cycle_done <= 1'h0;
		end else begin
			o_cycle_done <= (cnt == 1);
			if (i_step) begin
				cnt <= (i_code == 2'h2) ? LEN_I : LEN_D;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : dca_seq_model

// file: dca_arbiter_tb.sv
// Purpose: Self-checking bench for the DMA cycle arbiter
// Assumes: Sequencer model paces cycle ends on request
// Notes: State carries from test to test, so order matters
`timescale 1ns/1ps
module dca_arbiter_tb import dca_pkg::*; ;
	logic clk = 1'h0, rst = 1'h1, stp = 1'h0, wrote = 1'h0, ack_n = 1'h1;
	logic [1:0] ef = 2'h0;
	logic [3:0] sf = 4'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, strobe, susp, done;
	logic [1:0] bresp, rresp, code;
	logic [31:0] rdata;
	int fail_count = 0;
	int n_compared = 0;
	always #2.5 clk = ~clk;
	dca_arbiter i_dca_arbiter(.i_clk(clk), .i_sys_rst(rst), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .i_cycle_done(done), .i_instr_wrote_dma(wrote),
		.i_ext_demand_flag_ch0(ef[0]), .i_ext_demand_flag_ch1(ef[1]), .i_receive_flag(sf[0]),
		.i_transmit_flag(sf[1]), .i_rx_queue_nonempty(sf[2]), .i_tx_queue_space_flag(sf[3]),
		.i_hold_ack_n(ack_n), .o_grant_code(code), .o_grant_strobe(strobe), .o_suspend_instr(susp));
	dca_seq_model i_dca_seq_model(.i_clk(clk), .i_sys_rst(rst), .i_step(stp), .i_code(code),
		.o_cycle_done(done));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'h0;
		wd = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			ad = ad | awready;
			wd = wd | wready;
		end
		bready <= 1'h1;
		do @(posedge clk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk(bresp, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge clk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, e);
		chk(rresp, er);
	endtask : rd
	task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
		wr(OFS_CTL0, {24'h0, c0}, RESP_OKAY);
		wr(OFS_CTL1, {24'h0, c1}, RESP_OKAY);
	endtask : cfg
	// Ends the running cycle, then judges the next grant
	task automatic step(input logic [1:0] e);
		stp <= 1'h1;
		@(posedge clk);
		stp <= 1'h0;
		do @(posedge clk); while (strobe !== 1'h1);
		chk(code, e);
		chk(susp, e != 2'h2);
		@(posedge clk);
		chk(strobe, 1'h0);
	endtask : step
	task automatic t_regs();
		chk(code, 2'h2);
		rd(OFS_STAT, 32'h0000000D, RESP_OKAY);
		wr(OFS_CTL0, 32'h000000A4, RESP_OKAY);
		rd(OFS_CTL0, 32'h000000A4, RESP_OKAY);
		wr(OFS_STAT, 32'hFFFFFFFF, RESP_OKAY);
		wr(8'h20, 32'h1, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(OFS_CTL0, 32'h0, RESP_OKAY);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_alt();
		cfg(8'h01, 8'h00);
		step(2'h0);
		step(2'h2);
		step(2'h0);
		step(2'h2);
		cfg(8'h01, 8'h01);
		step(2'h1);
		step(2'h2);
		step(2'h0);
		step(2'h2);
		cfg(8'h00, 8'h01);
		step(2'h1);
		step(2'h2);
		$display("t_alt done");
	endtask : t_alt
	task automatic t_prio();
		cfg(8'h05, 8'h05);
		step(2'h0);
		step(2'h0);
		cfg(8'h04, 8'h05);
		step(2'h1);
		cfg(8'h05, 8'h00);
		wrote <= 1'h1;
		step(2'h0);
		cfg(8'h00, 8'h00);
		step(2'h2);
		cfg(8'h05, 8'h00);
		step(2'h2);
		step(2'h2);
		wrote <= 1'h0;
		step(2'h0);
		cfg(8'h00, 8'h00);
		step(2'h2);
		wr(OFS_DST0, 32'h85, RESP_OKAY);
		sf <= 4'h8;
		cfg(8'h89, 8'h05);
		step(2'h0);
		step(2'h1);
		step(2'h1);
		cfg(8'h89, 8'h00);
		step(2'h2);
		step(2'h0);
		sf <= 4'h0;
		cfg(8'h00, 8'h00);
		step(2'h2);
		$display("t_prio done");
	endtask : t_prio
	task automatic t_demand();
		cfg(8'h0D, 8'h0D);
		step(2'h2);
		ef <= 2'h2;
		step(2'h1);
		ef <= 2'h3;
		step(2'h0);
		ef <= 2'h0;
		wr(OFS_SRC0, 32'h99, RESP_OKAY);
		wr(OFS_DST1, 32'h99, RESP_OKAY);
		sf <= 4'h3;
		cfg(8'h39, 8'h89);
		step(2'h1);
		cfg(8'h29, 8'h89);
		step(2'h0);
		sf <= 4'h2;
		step(2'h1);
		wr(OFS_SRC0, 32'hF4, RESP_OKAY);
		sf <= 4'h4;
		cfg(8'h29, 8'h00);
		step(2'h0);
		step(2'h0);
		sf <= 4'h0;
		step(2'h2);
		$display("t_demand done");
	endtask : t_demand
	task automatic t_hold();
		cfg(8'h05, 8'h00);
		wr(OFS_PWR, 32'h2, RESP_OKAY);
		step(2'h2);
		ack_n <= 1'h0;
		repeat (4) @(posedge clk);
		step(2'h0);
		wr(OFS_PWR, 32'h1, RESP_OKAY);
		step(2'h2);
		cfg(8'hA5, 8'h00);
		step(2'h0);
		ack_n <= 1'h1;
		cfg(8'h05, 8'h00);
		step(2'h0);
		wr(OFS_PWR, 32'h0, RESP_OKAY);
		ack_n <= 1'h0;
		repeat (4) @(posedge clk);
		step(2'h0);
		$display("t_hold done");
	endtask : t_hold
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		t_regs();
		t_alt();
		t_prio();
		t_demand();
		t_hold();
		finish_test();
	end
	// Whole run needs a few hundred cycles
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule : dca_arbiter_tb
